// file: rtl/config_protect_debug_bank.sv
// Purpose: Configuration bytes for debug, instruction set, programming entry,
//          stack fault reset and program memory code protection
// Assumes: Values load from nonvolatile storage as unprogrammed defaults at rst
// Notes:   Protect bits can only be cleared through the register port
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_cfg.svh"

module config_protect_debug_bank #(
  parameter int          ADDR_W    = 24,
  parameter logic [23:0] MEM_BYTES = `PROG_MEM_BYTES
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  // Core controls
  output logic                   debug_enable,
  output logic                   extended_isa_enable,
  output logic                   single_supply_prog_enable,
  output logic                   stack_fault_reset_enable,
  // Stack fault to reset
  input  wire logic              stack_full,
  input  wire logic              stack_underflow,
  output logic                   stack_reset_req,
  // Programming entry pin
  input  wire logic              prog_entry_pin,
  output logic                   prog_mode_entry,
  // Code protect query
  input  wire logic [ADDR_W-1:0] fetch_addr,
  output logic                   fetch_protected,
  // Shared pins: a is debug_pin_a, b is debug_pin_b, index 0 is a
  input  wire logic [1:0]        debug_pin_in,
  output logic [1:0]             debug_pin_out,
  output logic [1:0]             debug_pin_oe,
  // Core GPIO side of the shared pins
  input  wire logic [1:0]        gpio_out,
  input  wire logic [1:0]        gpio_oe,
  output logic [1:0]             gpio_in,
  // Debugger side of the shared pins
  input  wire logic [1:0]        dbg_out,
  input  wire logic [1:0]        dbg_oe,
  output logic [1:0]             dbg_in
);

  cfg_bank_pkg::bank_state_s st_q;
  cfg_bank_pkg::bank_state_s st_d;

  logic prot_hit;

  // ****************************************
  // Address decode and clear-only merge
  // ****************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [23:0] reg_off);
    hit = 24'(a) == reg_off;
  endfunction : hit

  // Written zeros clear, written ones leave the bit alone
  function automatic logic [3:0] clear_only(input logic [3:0] cur, input logic [3:0] wr);
    clear_only = cur & wr;
  endfunction : clear_only

  protect_decoder #(
    .ADDR_W    (ADDR_W),
    .MEM_BYTES (MEM_BYTES)
  ) u_decoder (
    .addr          (fetch_addr),
    .blk_cp_n      (st_q.blk_cp),
    .boot_cp_n     (st_q.boot_cp),
    .protected_hit (prot_hit),
    .boot_hit      ()
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic dbg_on;
    logic [3:0] boot_w;
    dbg_on = 1'b0;
    boot_w = 4'h0;
    st_d = st_q;
    dbg_on = ~st_q.dbg_cfg[`DBG_DISABLE_BIT];
    boot_w = {3'h7, reg_wdata[`BOOT_PROT_BIT]};

    if (reg_wr && hit(reg_addr, `DBG_ISA_CFG_ADDR))
      st_d.dbg_cfg = reg_wdata & `DBG_ISA_IMPL_MASK;
    // Hardware also refuses to reopen a block
    if (reg_wr && hit(reg_addr, `BLK_PROT_CFG_ADDR))
      st_d.blk_cp = clear_only(st_q.blk_cp, reg_wdata[3:0]);
    if (reg_wr && hit(reg_addr, `BOOT_PROT_CFG_ADDR))
      st_d.boot_cp = clear_only({3'h7, st_q.boot_cp}, boot_w) == 4'hf;

    // Unmapped reads return zero
    st_d.rdata = 8'h00;
    if (reg_rd && hit(reg_addr, `DBG_ISA_CFG_ADDR))
      st_d.rdata = st_q.dbg_cfg & `DBG_ISA_IMPL_MASK;
    else if (reg_rd && hit(reg_addr, `BLK_PROT_CFG_ADDR))
      st_d.rdata = {4'h0, st_q.blk_cp};
    else if (reg_rd && hit(reg_addr, `BOOT_PROT_CFG_ADDR))
      st_d.rdata = {1'b0, st_q.boot_cp, 6'h00};

    st_d.stk_rst = st_q.dbg_cfg[`STKRST_BIT] && (stack_full || stack_underflow);
    st_d.prot    = prot_hit;

    // Pins come from outside: two flops before use
    st_d.pin_sync1 = debug_pin_in;
    st_d.pin_sync2 = st_q.pin_sync1;
    st_d.entry_sync = {st_q.entry_sync[0], prog_entry_pin};
    st_d.entry_prev = st_q.entry_sync[1];
    st_d.prog_entry = st_q.dbg_cfg[`SSPROG_BIT] && st_q.entry_sync[1] && !st_q.entry_prev;

    // Pin ownership follows the debug-disable bit
    st_d.pin_out = dbg_on ? dbg_out : gpio_out;
    st_d.pin_oe  = dbg_on ? dbg_oe : gpio_oe;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q          <= '0;
      st_q.dbg_cfg  <= `DBG_ISA_RESET;
      st_q.blk_cp   <= `BLK_PROT_RESET;
      st_q.boot_cp  <= `BOOT_PROT_RESET;
    end
    else
      st_q <= st_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata                 = st_q.rdata;
  assign debug_enable              = ~st_q.dbg_cfg[`DBG_DISABLE_BIT];
  assign extended_isa_enable       = st_q.dbg_cfg[`XISA_BIT];
  assign single_supply_prog_enable = st_q.dbg_cfg[`SSPROG_BIT];
  assign stack_fault_reset_enable  = st_q.dbg_cfg[`STKRST_BIT];
  assign stack_reset_req           = st_q.stk_rst;
  assign prog_mode_entry           = st_q.prog_entry;
  assign fetch_protected           = st_q.prot;
  assign debug_pin_out             = st_q.pin_out;
  assign debug_pin_oe              = st_q.pin_oe;
  // Each side sees the pins only while it owns them
  assign gpio_in = debug_enable ? 2'h0 : st_q.pin_sync2;
  assign dbg_in  = debug_enable ? st_q.pin_sync2 : 2'h0;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_rd_dbg;
    reg_rd && hit(reg_addr, `DBG_ISA_CFG_ADDR);
  endsequence

  sequence s_wr_blk;
    reg_wr && hit(reg_addr, `BLK_PROT_CFG_ADDR);
  endsequence

  chk_debug_pin_owner: assert property (
    debug_enable |=> (debug_pin_oe == $past(dbg_oe)) || !debug_enable)
    else $error("Shared pins not handed to debugger");

  chk_gpio_pin_owner: assert property (
    !rst && !debug_enable && $stable(debug_enable) |=> debug_pin_out == $past(gpio_out))
    else $error("Shared pins not handed to GPIO");

  chk_isa_follows_write: assert property (
    reg_wr && hit(reg_addr, `DBG_ISA_CFG_ADDR) |=> extended_isa_enable == $past(reg_wdata[`XISA_BIT]))
    else $error("Extended ISA bit did not follow write");

  chk_prog_entry_gate: assert property (
    prog_mode_entry |-> $past(single_supply_prog_enable))
    else $error("Programming entry while disabled");

  chk_stack_reset_map: assert property (
    (stack_full || stack_underflow) |=> stack_reset_req == $past(stack_fault_reset_enable))
    else $error("Stack fault reset mismatch");

  chk_unused_read_zero: assert property (
    s_rd_dbg |=> (reg_rdata & ~`DBG_ISA_IMPL_MASK) == 8'h00)
    else $error("Unimplemented bits read nonzero");

  chk_protect_clear_only: assert property (
    s_wr_blk ##1 1'b1 |-> (st_q.blk_cp & ~$past(st_q.blk_cp)) == 4'h0)
    else $error("Protect bit reopened");

  chk_boot_protect_map: assert property (
    24'(fetch_addr) < `BOOT_BLOCK_BYTES |=> fetch_protected == !$past(st_q.boot_cp))
    else $error("Boot block protection mismatch");

  chk_block_protect_map: assert property (
    (24'(fetch_addr) >= `BOOT_BLOCK_BYTES) && (st_q.blk_cp == 4'hf) |=> !fetch_protected)
    else $error("Open block reported protected");

  chk_all_blocks_locked: assert property (
    (24'(fetch_addr) >= `BOOT_BLOCK_BYTES) && (24'(fetch_addr) < MEM_BYTES) && (st_q.blk_cp == 4'h0)
      |=> fetch_protected)
    else $error("Locked block reported open");

  chk_entry_one_pulse: assert property (
    prog_mode_entry |=> !prog_mode_entry)
    else $error("Programming entry pulse too long");

endmodule : config_protect_debug_bank
`default_nettype wire

// file: rtl/cfg_bank_cfg.svh
// Purpose: Offsets, field positions, reset values of the configuration bank
// Assumes: Byte-addressed configuration space, 8-bit registers
// Notes:   Definitions only
`ifndef CFG_BANK_CFG_SVH
`define CFG_BANK_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define DBG_ISA_CFG_ADDR    24'h300006
`define BLK_PROT_CFG_ADDR   24'h300008
`define BOOT_PROT_CFG_ADDR  24'h300009

// ****************************************
// Field positions
// ****************************************
`define DBG_DISABLE_BIT     7
`define XISA_BIT            6
`define SSPROG_BIT          2
`define STKRST_BIT          0
`define BOOT_PROT_BIT       6
`define DBG_ISA_IMPL_MASK   8'hc5

// ****************************************
// Unprogrammed values and sizes
// ****************************************
`define DBG_ISA_RESET       8'h85
`define BLK_PROT_RESET      4'hf
`define BOOT_PROT_RESET     1'b1
`define BOOT_BLOCK_BYTES    24'h000800
`define PROG_MEM_BYTES      24'h008000

`endif

// file: rtl/cfg_bank_pkg.sv
// Purpose: Types shared by the configuration bank
// Assumes: Constants live in cfg_bank_cfg.svh
// Notes:   No imports anywhere; use cfg_bank_pkg::name
package cfg_bank_pkg;

  typedef struct packed {
    logic [7:0] dbg_cfg;
    logic [3:0] blk_cp;
    logic       boot_cp;
    logic [7:0] rdata;
    logic       stk_rst;
    logic       prot;
    logic [1:0] pin_sync1;
    logic [1:0] pin_sync2;
    logic [1:0] entry_sync;
    logic       entry_prev;
    logic       prog_entry;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
  } bank_state_s;

endpackage : cfg_bank_pkg

// file: rtl/protect_decoder.sv
// Purpose: Map a program memory address onto its code-protect bit
// Assumes: Four equal blocks; boot block at the bottom carved out of block 0
// Notes:   Purely combinational; caller registers the answer
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_cfg.svh"

module protect_decoder #(
  parameter int             ADDR_W    = 24,
  parameter logic [23:0]    MEM_BYTES = `PROG_MEM_BYTES
) (
  // Query
  input  wire logic [ADDR_W-1:0] addr,
  // Protect bits, active low
  input  wire logic [3:0]        blk_cp_n,
  input  wire logic              boot_cp_n,
  // Answer
  output logic                   protected_hit,
  output logic                   boot_hit
);

  localparam int BLK_SHIFT = $clog2(MEM_BYTES) - 2;

  logic [1:0] blk_idx;
  logic       in_range;

  assign blk_idx  = addr[BLK_SHIFT +: 2];
  assign in_range = 24'(addr) < MEM_BYTES;
  assign boot_hit = 24'(addr) < `BOOT_BLOCK_BYTES;

  // Past the end of memory nothing is protected
  always_comb
  begin
    if (boot_hit)
      protected_hit = ~boot_cp_n;
    else if (in_range)
      protected_hit = ~blk_cp_n[blk_idx];
    else
      protected_hit = 1'b0;
  end

endmodule : protect_decoder
`default_nettype wire

// file: dv/debug_tool_model.sv
// Purpose: External debugger tool on the two shared pins
// Assumes: Pins carry pull-ups
// Notes:   Resolves pin level from both drivers
`timescale 1ns/1ps
`default_nettype none

module debug_tool_model (
  // Device side
  input  wire logic [1:0] dut_out,
  input  wire logic [1:0] dut_oe,
  // Tool side
  input  wire logic [1:0] tool_out,
  input  wire logic [1:0] tool_oe,
  // Resolved pins
  output logic [1:0]      pin_level
);
  // Released pin floats up, never holds the last value
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      pin_level[i] = dut_oe[i] ? dut_out[i] : (tool_oe[i] ? tool_out[i] : 1'b1);
  end
endmodule : debug_tool_model
`default_nettype wire

// file: dv/testbench.sv
// Purpose: Self-checking bench of the configuration bank
// Assumes: 32K program memory, blocks of 0x2000
// Notes:   Register port tasks drive at the rising edge
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [23:0] reg_addr = '0, fetch_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata;
  logic dbg_en, xisa, ssp, stk_en, stack_full = 1'b0, stack_underflow = 1'b0, stk_req;
  logic prog_pin = 1'b0, prog_entry, fprot, seen;
  logic [1:0] pin_lvl, pin_out, pin_oe, gpio_in, dbg_in;
  logic [1:0] gpio_out = 2'h1, gpio_oe = 2'h3, dbg_out = 2'h2, dbg_oe = 2'h3;
  logic [1:0] tool_out = 2'h1, tool_oe = 2'h0;
  int fails = 0;
  int n_compared = 0;

  always #10 mclk = ~mclk;

  config_protect_debug_bank dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_enable(dbg_en),
    .extended_isa_enable(xisa), .single_supply_prog_enable(ssp), .stack_fault_reset_enable(stk_en),
    .stack_full(stack_full), .stack_underflow(stack_underflow), .stack_reset_req(stk_req),
    .prog_entry_pin(prog_pin), .prog_mode_entry(prog_entry), .fetch_addr(fetch_addr),
    .fetch_protected(fprot), .debug_pin_in(pin_lvl), .debug_pin_out(pin_out), .debug_pin_oe(pin_oe),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .dbg_out(dbg_out), .dbg_oe(dbg_oe),
    .dbg_in(dbg_in));

  debug_tool_model tool_u (.dut_out(pin_out), .dut_oe(pin_oe), .tool_out(tool_out),
    .tool_oe(tool_oe), .pin_level(pin_lvl));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [23:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, exp);
  endtask : rd

  task automatic ctl(input logic [3:0] exp);
    #1 chk("controls", {4'h0, ~dbg_en, xisa, ssp, stk_en}, {4'h0, exp});
  endtask : ctl

  // Stack fault pulse; underflow used when uf is high, full otherwise
  task automatic stk(input logic uf, input logic exp);
    @(posedge mclk);
    stack_full <= ~uf; stack_underflow <= uf;
    @(posedge mclk);
    stack_full <= 1'b0; stack_underflow <= 1'b0;
    #1 chk("stack_req", {7'h0, stk_req}, {7'h0, exp});
    @(posedge mclk);
    #1 chk("stack_req_end", {7'h0, stk_req}, 8'h00);
  endtask : stk

  // Pin rise, bounded watch for the entry pulse
  task automatic prog(input logic exp);
    seen = 1'b0;
    @(posedge mclk) prog_pin <= 1'b1;
    repeat (8) @(posedge mclk) #1 seen |= (prog_entry === 1'b1);
    @(posedge mclk) prog_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("prog_entry", {7'h0, seen}, {7'h0, exp});
  endtask : prog

  task automatic fetch(input logic [23:0] a, input logic exp);
    @(posedge mclk) fetch_addr <= a;
    @(posedge mclk);
    #1 chk("fetch_prot", {7'h0, fprot}, {7'h0, exp});
  endtask : fetch

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(24'h300006, 8'h85);
    rd(24'h300008, 8'h0f);
    rd(24'h300009, 8'h40);
    rd(24'h300007, 8'h00);
    ctl(4'hb);
    $display("test reset_values done");
    stk(1'b0, 1'b1);
    stk(1'b1, 1'b1);
    prog(1'b1);
    repeat (4) @(posedge mclk);
    #1 chk("pin_out", {6'h0, pin_out}, 8'h01);
    chk("pin_oe", {6'h0, pin_oe}, 8'h03);
    chk("gpio_in", {6'h0, gpio_in}, 8'h01);
    chk("dbg_in", {6'h0, dbg_in}, 8'h00);
    $display("test gpio_owner done");
    wr(24'h300006, 8'hff);
    rd(24'h300006, 8'hc5);
    ctl(4'hf);
    wr(24'h300006, 8'h00);
    ctl(4'h0);
    rd(24'h300006, 8'h00);
    stk(1'b0, 1'b0);
    prog(1'b0);
    repeat (4) @(posedge mclk);
    #1 chk("pin_out", {6'h0, pin_out}, 8'h02);
    @(posedge mclk);
    dbg_oe <= 2'h0;
    tool_oe <= 2'h3;
    repeat (4) @(posedge mclk);
    #1 chk("dbg_in", {6'h0, dbg_in}, 8'h01);
    chk("gpio_in", {6'h0, gpio_in}, 8'h00);
    $display("test debugger_owner done");
    fetch(24'h002000, 1'b0);
    wr(24'h300008, 8'h0d);
    fetch(24'h002000, 1'b1);
    fetch(24'h003fff, 1'b1);
    fetch(24'h004000, 1'b0);
    wr(24'h300008, 8'h0f);
    rd(24'h300008, 8'h0d);
    fetch(24'h000100, 1'b0);
    wr(24'h300009, 8'h00);
    rd(24'h300009, 8'h00);
    fetch(24'h000100, 1'b1);
    fetch(24'h000800, 1'b0);
    wr(24'h300008, 8'h06);
    rd(24'h300008, 8'h04);
    fetch(24'h000800, 1'b1);
    fetch(24'h004000, 1'b0);
    fetch(24'h006000, 1'b1);
    wr(24'h300008, 8'h00);
    fetch(24'h004000, 1'b1);
    fetch(24'h008000, 1'b0);
    wr(24'h300009, 8'h40);
    rd(24'h300009, 8'h00);
    $display("test code_protect done");
    final_report();
  end

  initial
  begin
    #(20 * 2000);
    fails++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
